/* File: src/ibc_buffer_config.v */
// Interpolation buffer configuration and management for a servo drive.
// Assumes one clock, inputs synchronous to it, and a master that issues one
// object access at a time on the od_* port and waits for od_ack.
`timescale 1ns/1ps
`include "ibc_regs.vh"

module ibc_buffer_config (
    input wire clk,
    input wire rst,
    input wire od_wr,
    input wire od_rd,
    input wire [15:0] od_index,
    input wire [7:0] od_subindex,
    input wire [31:0] od_wdata,
    output reg od_ack,
    output reg od_abort,
    output reg [31:0] od_rdata,
    input wire rec_valid,
    input wire [`IBC_REC_WIDTH-1:0] rec_data,
    output reg rec_ready,
    output reg out_valid,
    output wire [`IBC_REC_WIDTH-1:0] out_data,
    input wire out_take,
    input wire [7:0] seg_time_value,
    output reg [17:0] seg_duration_us,
    output reg access_enabled
);

    // Configuration record held in the device.
    reg [7:0] segment_time_scale;
    reg [31:0] buffer_capacity;
    reg [31:0] buffer_fill_count;
    reg [7:0] buffer_organisation;
    reg [31:0] next_free_entry;
    reg [7:0] record_byte_length;
    reg [7:0] buffer_clear_control;
    reg [31:0] oldest_entry;

    reg [31:0] next_fill;
    reg [31:0] next_free;
    reg [31:0] next_oldest;
    reg accept;
    reg take;
    reg store;
    wire [31:0] cap_eff;
    wire is_ring;
    wire full;

    // Microseconds per count of a time-unit code; zero for a code never stored.
    function [17:0] unit_scale;
        input [7:0] code;
        begin
            case (code)
                `IBC_UNIT_MS: unit_scale = `IBC_SCALE_MS;
                `IBC_UNIT_100US: unit_scale = `IBC_SCALE_100US;
                `IBC_UNIT_10US: unit_scale = `IBC_SCALE_10US;
                `IBC_UNIT_US: unit_scale = `IBC_SCALE_US;
                default: unit_scale = 18'h00000;
            endcase
        end
    endfunction

    // Index after p, wrapping to zero at the usable capacity.
    function [31:0] wrap_inc;
        input [31:0] p;
        input [31:0] cap;
        begin
            if (p + `IBC_ONE32 >= cap) begin
                wrap_inc = `IBC_ZERO32;
            end else begin
                wrap_inc = p + `IBC_ONE32;
            end
        end
    endfunction

    // True for the only two codes that the organisation and clear entries accept.
    function bin_code_ok;
        input [7:0] code;
        begin
            bin_code_ok = (code == `IBC_ORG_FIFO) || (code == `IBC_ORG_RING);
        end
    endfunction

    // The capacity field may promise more than the storage has; the smaller wins.
    assign cap_eff = (buffer_capacity > `IBC_DEPTH_32) ? `IBC_DEPTH_32 : buffer_capacity;
    assign is_ring = (buffer_organisation == `IBC_ORG_RING);
    assign full = (buffer_fill_count >= cap_eff);

    // The head record comes from the storage read register, one edge behind the pointer.
    ibc_rec_mem u_mem (
        .clk(clk),
        .wr_en(store),
        .wr_addr(next_free_entry[`IBC_MEM_AW-1:0]),
        .wr_data(rec_data),
        .rd_addr(oldest_entry[`IBC_MEM_AW-1:0]),
        .rd_data(out_data)
    );

    // Access port decode: which writes are legal and what they carry.
    // A write that matches no legal entry leaves wr_ok low and is answered by an abort.
    reg wr_ok;
    reg wr_scale;
    reg wr_cap;
    reg wr_fill;
    reg wr_org;
    reg wr_free;
    reg wr_len;
    reg wr_clear;
    always @* begin
        wr_scale = 1'b0;
        wr_cap = 1'b0;
        wr_fill = 1'b0;
        wr_org = 1'b0;
        wr_free = 1'b0;
        wr_len = 1'b0;
        wr_clear = 1'b0;
        if (od_wr && od_index == `IBC_IDX_TIME_PERIOD && od_subindex == `IBC_SUB_TIME_SCALE) begin
            // Only the four documented unit codes are stored.
            wr_scale = (od_wdata[7:0] == `IBC_UNIT_MS) || (od_wdata[7:0] == `IBC_UNIT_100US) ||
                       (od_wdata[7:0] == `IBC_UNIT_10US) || (od_wdata[7:0] == `IBC_UNIT_US);
        end
        if (od_wr && od_index == `IBC_IDX_BUF_CONFIG) begin
            case (od_subindex)
                // Geometry changes only while access is closed, so stored
                // records never straddle a capacity or organisation change.
                `IBC_SUB_CAPACITY: wr_cap = !access_enabled;
                `IBC_SUB_FILL: wr_fill = !access_enabled && (od_wdata <= cap_eff);
                `IBC_SUB_ORGANISATION: wr_org = !access_enabled && bin_code_ok(od_wdata[7:0]);
                `IBC_SUB_NEXT_FREE: wr_free = !access_enabled && (od_wdata < cap_eff);
                `IBC_SUB_RECORD_LEN: wr_len = 1'b1;
                `IBC_SUB_CLEAR: wr_clear = bin_code_ok(od_wdata[7:0]);
                default: wr_clear = 1'b0;
            endcase
        end
        wr_ok = wr_scale | wr_cap | wr_fill | wr_org | wr_free | wr_len | wr_clear;
    end

    // Record flow: acceptance, draining, and the next pointer and count values.
    // A take and an accept in one cycle cancel in the count and move both pointers.
    always @* begin
        accept = rec_valid && rec_ready && access_enabled;
        take = out_take && out_valid && access_enabled;
        store = accept;
        next_fill = buffer_fill_count;
        next_free = next_free_entry;
        next_oldest = oldest_entry;
        if (take) begin
            next_oldest = wrap_inc(oldest_entry, cap_eff);
            next_fill = buffer_fill_count - `IBC_ONE32;
        end
        if (accept) begin
            next_free = wrap_inc(next_free_entry, cap_eff);
            if (full && !take) begin
                // Ring overwrite of the oldest record keeps the count at capacity.
                next_oldest = wrap_inc(oldest_entry, cap_eff);
            end else begin
                next_fill = next_fill + `IBC_ONE32;
            end
        end
        if (wr_clear && od_wdata[7:0] == `IBC_CLEAR_DISABLE) begin
            // Clearing discards every stored record at once.
            next_fill = `IBC_ZERO32;
            next_free = `IBC_ZERO32;
            next_oldest = `IBC_ZERO32;
        end
        if (wr_fill) begin
            next_fill = od_wdata;
        end
        if (wr_free) begin
            next_free = od_wdata;
        end
    end

    // Configuration and buffer state registers.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            segment_time_scale <= `IBC_RST_SCALE;
            buffer_capacity <= `IBC_DEPTH_32;
            buffer_fill_count <= `IBC_ZERO32;
            buffer_organisation <= `IBC_ORG_FIFO;
            next_free_entry <= `IBC_ZERO32;
            record_byte_length <= `IBC_RST_RECORD_LEN;
            buffer_clear_control <= `IBC_CLEAR_DISABLE;
            oldest_entry <= `IBC_ZERO32;
            access_enabled <= 1'b0;
        end else begin
            if (wr_scale) begin
                segment_time_scale <= od_wdata[7:0];
            end
            if (wr_cap) begin
                buffer_capacity <= od_wdata;
            end
            if (wr_org) begin
                buffer_organisation <= od_wdata[7:0];
            end
            if (wr_len) begin
                record_byte_length <= od_wdata[7:0];
            end
            if (wr_clear) begin
                buffer_clear_control <= od_wdata[7:0];
                access_enabled <= (od_wdata[7:0] == `IBC_CLEAR_ENABLE);
            end
            buffer_fill_count <= next_fill;
            next_free_entry <= next_free;
            oldest_entry <= next_oldest;
        end
    end

    // Stream handshakes are registered; ready looks one cycle ahead so a
    // FIFO never takes a record it has no room for.
    // A capacity of zero keeps ready low, since no record could ever be stored.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (wr_clear) begin
                rec_ready <= (od_wdata[7:0] == `IBC_CLEAR_ENABLE) && (cap_eff != `IBC_ZERO32) &&
                             (is_ring || next_fill < cap_eff);
            end else begin
                rec_ready <= access_enabled && (cap_eff != `IBC_ZERO32) &&
                             (is_ring || next_fill < cap_eff) && !wr_fill && !wr_free;
            end
            // Head data lags a pointer change by one edge, so valid waits for
            // a quiet cycle; a master streaming every cycle starves the drain.
            out_valid <= access_enabled && !wr_clear && (next_fill != `IBC_ZERO32) &&
                         !accept && !take && !wr_fill && !wr_free;
        end
    end

    // Segment duration in microseconds from the time value input and the stored time unit.
    // The largest product, 255 counts of 1000 us, still fits the 18-bit output.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            seg_duration_us <= 18'h00000;
        end else begin
            seg_duration_us <= {10'h000, seg_time_value} * unit_scale(segment_time_scale);
        end
    end

    // Read multiplexer for the configuration record.
    reg [31:0] rd_value;
    reg rd_hit;
    always @* begin
        rd_value = `IBC_ZERO32;
        rd_hit = 1'b0;
        if (od_index == `IBC_IDX_TIME_PERIOD) begin
            case (od_subindex)
                `IBC_SUB_COUNT: begin
                    rd_value = `IBC_TIME_PERIOD_ENTRIES;
                    rd_hit = 1'b1;
                end
                `IBC_SUB_TIME_SCALE: begin
                    rd_value = {{24{segment_time_scale[7]}}, segment_time_scale};
                    rd_hit = 1'b1;
                end
                default: rd_hit = 1'b0;
            endcase
        end else if (od_index == `IBC_IDX_BUF_CONFIG) begin
            rd_hit = 1'b1;
            case (od_subindex)
                `IBC_SUB_COUNT: rd_value = `IBC_BUF_CONFIG_ENTRIES;
                `IBC_SUB_CAPACITY: rd_value = buffer_capacity;
                `IBC_SUB_FILL: rd_value = buffer_fill_count;
                `IBC_SUB_ORGANISATION: rd_value = {24'h000000, buffer_organisation};
                `IBC_SUB_NEXT_FREE: rd_value = next_free_entry;
                `IBC_SUB_RECORD_LEN: rd_value = {24'h000000, record_byte_length};
                `IBC_SUB_CLEAR: rd_value = {24'h000000, buffer_clear_control};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // One acknowledge per access; a refused write or unknown entry aborts.
    // Read data is kept between reads, so a master may fetch it late.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            od_ack <= 1'b0;
            od_abort <= 1'b0;
            od_rdata <= `IBC_ZERO32;
        end else begin
            od_ack <= od_wr || od_rd;
            od_abort <= (od_wr && !wr_ok) || (od_rd && !od_wr && !rd_hit);
            if (od_rd && !od_wr && rd_hit) begin
                od_rdata <= rd_value;
            end
        end
    end

endmodule

/* File: src/ibc_regs.vh */
// Constants for the interpolation buffer configuration block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef IBC_REGS_VH
`define IBC_REGS_VH

// Object dictionary indices and sub-indices reached through the access port.
`define IBC_IDX_TIME_PERIOD 16'h60c2
`define IBC_IDX_BUF_CONFIG 16'h60c4
`define IBC_SUB_COUNT 8'h00
`define IBC_SUB_TIME_SCALE 8'h02
`define IBC_SUB_CAPACITY 8'h01
`define IBC_SUB_FILL 8'h02
`define IBC_SUB_ORGANISATION 8'h03
`define IBC_SUB_NEXT_FREE 8'h04
`define IBC_SUB_RECORD_LEN 8'h05
`define IBC_SUB_CLEAR 8'h06

// Entry counts reported at sub-index zero.
`define IBC_TIME_PERIOD_ENTRIES 32'h0000_0002
`define IBC_BUF_CONFIG_ENTRIES 32'h0000_0006

// Time-unit codes, two's complement: -3 down to -6.
`define IBC_UNIT_MS 8'hfd
`define IBC_UNIT_100US 8'hfc
`define IBC_UNIT_10US 8'hfb
`define IBC_UNIT_US 8'hfa

// Microseconds per count for each time-unit code.
`define IBC_SCALE_MS 18'h003e8
`define IBC_SCALE_100US 18'h00064
`define IBC_SCALE_10US 18'h0000a
`define IBC_SCALE_US 18'h00001

// Organisation and clear-control codes.
`define IBC_ORG_FIFO 8'h00
`define IBC_ORG_RING 8'h01
`define IBC_CLEAR_DISABLE 8'h00
`define IBC_CLEAR_ENABLE 8'h01

// Record storage geometry and reset values.
`define IBC_REC_WIDTH 32
`define IBC_MEM_DEPTH 16
`define IBC_MEM_AW 4
`define IBC_DEPTH_32 32'h0000_0010
`define IBC_RST_SCALE 8'hfd
`define IBC_RST_RECORD_LEN 8'h04
`define IBC_ZERO32 32'h0000_0000
`define IBC_ONE32 32'h0000_0001

`endif

/* File: src/ibc_rec_mem.v */
// Record storage for the interpolation buffer: one write port, one read port.
// Assumes a single clock; read data is registered and follows the address by one edge.
`timescale 1ns/1ps
`include "ibc_regs.vh"

module ibc_rec_mem (
    input wire clk,
    input wire wr_en,
    input wire [`IBC_MEM_AW-1:0] wr_addr,
    input wire [`IBC_REC_WIDTH-1:0] wr_data,
    input wire [`IBC_MEM_AW-1:0] rd_addr,
    output reg [`IBC_REC_WIDTH-1:0] rd_data
);

    reg [`IBC_REC_WIDTH-1:0] cells [0:`IBC_MEM_DEPTH-1];

    // Storage is not reset; validity is tracked by the fill count outside.
    always @(posedge clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        rd_data <= cells[rd_addr];
    end

endmodule

/* File: verification/ibc_buffer_config_sva.sv */
// Concurrent checks on the object port and stream handshakes of the buffer block.
// Assumes binding to the top module, one clock and the active-high async reset.
`timescale 1ns/1ps
`include "ibc_regs.vh"
module ibc_buffer_config_sva (
    input wire clk,
    input wire rst,
    input wire od_wr,
    input wire od_rd,
    input wire [15:0] od_index,
    input wire [7:0] od_subindex,
    input wire [31:0] od_wdata,
    input wire od_ack,
    input wire od_abort,
    input wire [31:0] od_rdata,
    input wire rec_ready,
    input wire out_valid,
    input wire out_take,
    input wire access_enabled
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A write into the configuration record, selected by entry.
    sequence s_cfg_wr(logic [7:0] sub);
        od_wr && od_index == `IBC_IDX_BUF_CONFIG && od_subindex == sub;
    endsequence
    a_ack_follows_req: assert property ((od_wr || od_rd) |=> od_ack)
        else $error("object request not acknowledged");
    a_ack_has_cause: assert property (od_ack |-> $past(od_wr) || $past(od_rd))
        else $error("acknowledge without request");
    a_count_entry_read: assert property ((od_rd && !od_wr && od_subindex == 8'h00 &&
        od_index == `IBC_IDX_BUF_CONFIG) |=> !od_abort && od_rdata == 32'h6)
        else $error("entry count read wrong");
    a_org_code_reject: assert property (s_cfg_wr(8'h03) ##0 od_wdata[7:0] > 8'h01 |=> od_abort)
        else $error("bad organisation code taken");
    a_clear_code_reject: assert property (s_cfg_wr(8'h06) ##0 od_wdata[7:0] > 8'h01 |=> od_abort)
        else $error("bad clear code taken");
    a_scale_code_reject: assert property ((od_wr && od_index == `IBC_IDX_TIME_PERIOD &&
        od_subindex == 8'h02 && (od_wdata[7:0] < 8'hfa || od_wdata[7:0] > 8'hfd))
        |=> od_abort)
        else $error("bad time unit code taken");
    a_clear_closes_all: assert property (s_cfg_wr(8'h06) ##0 od_wdata == 32'h0
        |=> !access_enabled && !rec_ready && !out_valid)
        else $error("clear left access open");
    a_enable_opens: assert property (s_cfg_wr(8'h06) ##0 od_wdata == 32'h1
        |=> access_enabled)
        else $error("enable did not open access");
    a_closed_not_ready: assert property (!access_enabled |-> !rec_ready)
        else $error("ready while access closed");
    a_capacity_locked: assert property (s_cfg_wr(8'h01) ##0 access_enabled |=> od_abort)
        else $error("capacity changed while open");
    a_take_drops_valid: assert property (out_valid && out_take |=> !out_valid)
        else $error("head valid held after take");
endmodule
bind ibc_buffer_config ibc_buffer_config_sva u_ibc_buffer_config_sva (.clk(clk), .rst(rst),
    .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_subindex(od_subindex),
    .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
    .rec_ready(rec_ready), .out_valid(out_valid), .out_take(out_take),
    .access_enabled(access_enabled));

/* File: verification/ibc_rec_source.sv */
// Master-side model that offers interpolation records, promptly or every other cycle.
// Assumes the block takes a record at a rising edge with valid and ready both high.
`timescale 1ns/1ps
module ibc_rec_source (
    input wire clk,
    input wire rst,
    input wire run,
    input wire slow,
    input wire [7:0] count,
    input wire [31:0] base,
    input wire rec_ready,
    output reg rec_valid,
    output reg [31:0] rec_data,
    output reg [7:0] sent
);
    reg phase;
    reg took;
    // Count records taken; dropping run restarts the count for the next burst.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sent <= 8'h00;
            took <= 1'b0;
        end else begin
            took <= rec_valid && rec_ready;
            if (!run)
                sent <= 8'h00;
            else if (rec_valid && rec_ready)
                sent <= sent + 8'h01;
        end
    end
    // An offer is held until taken; idle data is inverted so stale words never match.
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            rec_valid <= 1'b0;
            rec_data <= 32'h0000_0000;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            if (run && ((rec_valid && !took) || (sent < count && (!slow || phase)))) begin
                rec_valid <= 1'b1;
                rec_data <= base + {24'h000000, sent};
            end else begin
                rec_valid <= 1'b0;
                rec_data <= ~rec_data;
            end
        end
    end
endmodule

/* File: verification/interp_buffer_config_tb.sv */
// Self-checking bench for the interpolation buffer block and its record source.
// Assumes a 100 MHz clock; all bench inputs change at the falling edge.
`timescale 1ns/1ps
`include "ibc_regs.vh"
module interp_buffer_config_tb;
    logic clk = 1'b0, rst = 1'b1, od_wr = 1'b0, od_rd = 1'b0, out_take = 1'b0;
    logic run = 1'b0, slow = 1'b0;
    logic [15:0] od_index = 16'h0000;
    logic [7:0] od_subindex = 8'h00, seg_time_value = 8'h00, count = 8'h00, sent;
    logic [31:0] od_wdata = 32'h0000_0000, od_rdata, rec_data, out_data;
    logic [31:0] rec_base = 32'h5a00_0000;
    logic od_ack, od_abort, rec_valid, rec_ready, out_valid, access_enabled;
    logic [17:0] seg_duration_us;
    integer n_fail = 0, n_compared = 0, s;
    ibc_buffer_config u_ibc_buffer_config (.clk(clk), .rst(rst), .od_wr(od_wr), .od_rd(od_rd),
        .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_ack(od_ack),
        .od_abort(od_abort), .od_rdata(od_rdata), .rec_valid(rec_valid), .rec_data(rec_data),
        .rec_ready(rec_ready), .out_valid(out_valid), .out_data(out_data),
        .out_take(out_take), .seg_time_value(seg_time_value),
        .seg_duration_us(seg_duration_us), .access_enabled(access_enabled));
    ibc_rec_source u_ibc_rec_source (.clk(clk), .rst(rst), .run(run), .slow(slow),
        .count(count), .base(rec_base), .rec_ready(rec_ready), .rec_valid(rec_valid),
        .rec_data(rec_data), .sent(sent));
    // Free-running clock, 10 ns period.
    always #5 clk = ~clk;
    task close_out;
        begin
            if (n_fail == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // One object access: a one-cycle request, answer judged at the next falling edge,
    // then one idle cycle so that back-to-back calls never re-raise a strobe at once.
    task od(input w, input [15:0] i, input [7:0] sub, input [31:0] d, input ab);
        begin
            od_wr = w;
            od_rd = !w;
            od_index = i;
            od_subindex = sub;
            od_wdata = d;
            @(negedge clk);
            od_wr = 1'b0;
            od_rd = 1'b0;
            chk("od_ack", 1, od_ack);
            chk("od_abort", ab, od_abort);
            @(negedge clk);
        end
    endtask
    task wc(input [7:0] sub, input [31:0] d, input ab);
        od(1'b1, `IBC_IDX_BUF_CONFIG, sub, d, ab);
    endtask
    task rc(input [7:0] sub, input [31:0] exp);
        begin
            od(1'b0, `IBC_IDX_BUF_CONFIG, sub, 32'h0, 1'b0);
            chk("od_rdata", exp, od_rdata);
        end
    endtask
    // Offer n records and wait, bounded, until all are taken.
    task feed(input [7:0] n);
        integer k;
        begin
            count <= n;
            run <= 1'b1;
            for (k = 0; k < 80 && sent != n; k = k + 1)
                @(negedge clk);
            chk("records sent", n, sent);
            run <= 1'b0;
        end
    endtask
    // Take n records from the head, one take per two cycles at most.
    task drain(input integer n, input [31:0] first);
        integer j, k;
        begin
            for (j = 0; j < n; j = j + 1) begin
                for (k = 0; k < 20 && out_valid !== 1'b1; k = k + 1)
                    @(negedge clk);
                chk("out_valid", 1, out_valid);
                chk("out_data", first + j, out_data);
                out_take = 1'b1;
                @(negedge clk);
                out_take = 1'b0;
            end
        end
    endtask
    task t_reset_values;
        begin
            od(1'b0, `IBC_IDX_TIME_PERIOD, 8'h00, 32'h0, 1'b0);
            chk("period entries", 2, od_rdata);
            od(1'b0, `IBC_IDX_TIME_PERIOD, 8'h02, 32'h0, 1'b0);
            chk("time scale", 32'hffff_fffd, od_rdata);
            for (s = 0; s < 7; s = s + 1)
                rc(s, s == 0 ? 6 : s == 1 ? 16 : s == 5 ? 4 : 0);
            od(1'b0, `IBC_IDX_BUF_CONFIG, 8'h07, 32'h0, 1'b1);
            wc(8'h00, 32'h6, 1'b1);
        end
    endtask
    task t_time_units;
        begin
            seg_time_value = 8'hc8;
            for (s = 0; s < 4; s = s + 1) begin
                od(1'b1, `IBC_IDX_TIME_PERIOD, 8'h02, 32'hfd - s, 1'b0);
                @(negedge clk);
                chk("duration", 200 * (s == 0 ? 1000 : s == 1 ? 100 : s == 2 ? 10 : 1),
                    seg_duration_us);
            end
            od(1'b1, `IBC_IDX_TIME_PERIOD, 8'h02, 32'hf9, 1'b1);
            @(negedge clk);
            chk("duration kept", 200, seg_duration_us);
        end
    endtask
    task t_fifo_fill;
        begin
            wc(8'h03, 32'h2, 1'b1);
            wc(8'h01, 32'h4, 1'b0);
            wc(8'h06, 32'h1, 1'b0);
            wc(8'h01, 32'h8, 1'b1);
            feed(8'h04);
            repeat (2) @(negedge clk);
            chk("ready when full", 0, rec_ready);
            rc(8'h02, 32'h4);
            rc(8'h04, 32'h0);
            drain(4, rec_base);
            rc(8'h02, 32'h0);
        end
    endtask
    task t_clear_blocks;
        begin
            feed(8'h02);
            rc(8'h04, 32'h2);
            wc(8'h06, 32'h0, 1'b0);
            chk("access", 0, access_enabled);
            rc(8'h02, 32'h0);
            rc(8'h04, 32'h0);
            count <= 8'h06;
            run <= 1'b1;
            repeat (6) @(negedge clk);
            chk("ignored records", 0, sent);
            run <= 1'b0;
            rc(8'h02, 32'h0);
            wc(8'h06, 32'h2, 1'b1);
        end
    endtask
    task t_ring_wrap;
        begin
            wc(8'h03, 32'h1, 1'b0);
            wc(8'h01, 32'h3, 1'b0);
            wc(8'h06, 32'h1, 1'b0);
            slow <= 1'b1;
            feed(8'h05);
            slow <= 1'b0;
            rc(8'h02, 32'h3);
            rc(8'h04, 32'h2);
            rc(8'h03, 32'h1);
            drain(3, rec_base + 2);
            rc(8'h02, 32'h0);
        end
    endtask
    // A run takes well under a thousand cycles; the limit leaves ample room.
    initial begin
        #50000;
        n_fail = n_fail + 1;
        close_out;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_reset_values;
        t_time_units;
        t_fifo_fill;
        t_clear_blocks;
        t_ring_wrap;
        close_out;
    end
endmodule
